// ### rtl/smc_pkg.sv
// Purpose: shared constants and types of the standby mode controller
// Assumes: 32-bit apb data, one aligned word per register
// Notes: latencies are counted in sys_clk cycles
package smc_pkg;

  // register byte offsets
  localparam logic [7:0] REG_STAB_OFS = 8'h00;
  localparam logic [7:0] REG_CFG_OFS = 8'h04;
  localparam logic [7:0] REG_STAT_OFS = 8'h08;

  // reset values
  localparam logic [7:0] STAB_SEL_RST = 8'h04;
  localparam logic [3:0] CFG_RST = 4'h0;

  // config field positions
  localparam int CFG_T8A_EXT = 0;
  localparam int CFG_T8B_EXT = 1;
  localparam int CFG_WATCH_SUB = 2;
  localparam int CFG_SIO_EXT = 3;

  // status field positions
  localparam int STAT_HALT = 0;
  localparam int STAT_STOP = 1;
  localparam int STAT_STAB = 2;
  localparam int STAT_ON_SUB = 3;
  localparam int STAT_LAST_VEC = 4;
  localparam int STAT_STOP_REFUSED = 8;

  // wake latency from halt, in sys_clk cycles
  localparam int WAKE_VEC_CLK = 8;
  localparam int WAKE_NEXT_CLK = 2;
  localparam logic [3:0] WAKE_VEC_LOAD = 4'(WAKE_VEC_CLK - 2);
  localparam logic [3:0] WAKE_NEXT_LOAD = 4'(WAKE_NEXT_CLK - 2);

  // default least exponent of the stabilization count
  localparam int STAB_EXP_BASE_DEF = 12;

  typedef enum logic [2:0] {S_RUN, S_HALT, S_STOP, S_STAB, S_WAKE}
    smc_state_t;

  typedef struct packed {
    logic nmi_req;
    logic irq_req;
    logic irq_mask_flag;
    logic irq_priority_flag;
  } smc_irq_t;

  typedef struct packed {
    logic timer16;
    logic timer8a;
    logic timer8b;
    logic watch;
    logic wdt;
    logic uart;
    logic sound;
    logic van;
    logic lcd;
    logic adc;
    logic sio;
    logic ext_irq;
  } smc_per_run_t;

endpackage : smc_pkg

// ### rtl/smc_ctrl.sv
// Purpose: standby mode controller (halt, stop, stabilization, wake-up)
// Assumes: cpu, interrupt controller and apb master share sys_clk;
//   osc_ready comes from the analog oscillator and is synchronised
// Notes: apb answers with zero wait states
// Operation
// - halt gates cpu clock, oscillators keep running
// - stop instruction halts main oscillator
// - standby preserves all state untouched
// - stop only from main clock
// - interrupt stop exit waits selected stabilization
// - stabilization select resets to 04h, bytewide
// - stabilization count starts at oscillation restart
// - sub halt: 8-bit timers need external clock
// - sub halt: watch and sio by config, ext irq kept, others stop
// - halt stops adc; ext irq kept, sio kept on main clock
// - unmasked request clears halt, vector or next
// - halt wake latency 8 or 2 clocks
// - nmi clears halt, always vectored
// - reset clears halt, starts from reset vector
// - mask, priority, enable, in-service pick outcome
// - pending request at stop goes to stabilization wait
`timescale 1ns/1ns
module smc_ctrl #(
  parameter int STAB_EXP_BASE = smc_pkg::STAB_EXP_BASE_DEF,
  parameter int CNT_W = 24
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_instr,
  input wire logic stop_instr,
  input wire logic subclk_active,
  input wire smc_pkg::smc_irq_t irq,
  input wire logic irq_accept_enable,
  input wire logic in_service_priority,
  input wire logic osc_ready,
  output logic cpu_clk_en,
  output logic main_osc_en,
  output logic wake_pulse,
  output logic vector_take,
  output smc_pkg::smc_per_run_t per_run
);

  smc_pkg::smc_state_t state_q, state_d;
  logic [3:0] lat_q, lat_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic vec_q, vec_d;
  logic on_sub_q, on_sub_d;
  logic stop_path_q, stop_path_d;
  logic pulse_q, pulse_d;
  logic vtake_q, vtake_d;
  logic clk_en_q, clk_en_d;
  logic osc_en_q, osc_en_d;
  smc_pkg::smc_per_run_t per_q, per_d;
  logic [7:0] stab_sel_q, stab_sel_d;
  logic [3:0] cfg_q, cfg_d;
  logic refused_q, refused_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic err_q, err_d;
  logic osc_s1_q, osc_s2_q;
  logic wake_any, take_vec, refuse_set;
  logic [CNT_W-1:0] stab_term;
  logic [4:0] stab_shamt;
  logic setup, wr_en;
  logic [31:0] stat_word;

  // oscillator status crosses in from the analog side
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_ready;
      osc_s2_q <= osc_s1_q;
    end
  end

  // wake-up decision from the highest pending request
  always_comb begin
    wake_any = irq.nmi_req | (irq.irq_req & ~irq.irq_mask_flag);
    take_vec = irq.nmi_req
      | (~irq.irq_priority_flag & irq_accept_enable)
      | (irq.irq_priority_flag & irq_accept_enable
         & in_service_priority);
  end

  // only the low three select bits matter; wider codes wrap
  always_comb begin
    stab_shamt = 5'(STAB_EXP_BASE + int'(stab_sel_q[2:0]));
    stab_term = ({{(CNT_W-1){1'b0}}, 1'b1} << stab_shamt)
      - {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // mode sequencer; no state outside this block is touched on entry,
  // so the cpu and peripherals keep their contents while gated
  always_comb begin
    state_d = state_q;
    lat_d = lat_q;
    cnt_d = cnt_q;
    vec_d = vec_q;
    on_sub_d = on_sub_q;
    stop_path_d = stop_path_q;
    refuse_set = 1'b0;
    pulse_d = 1'b0;
    vtake_d = 1'b0;
    case (state_q)
      smc_pkg::S_RUN: begin
        if (halt_instr) begin
          state_d = smc_pkg::S_HALT;
          on_sub_d = subclk_active;
          stop_path_d = 1'b0;
        end else if (stop_instr) begin
          if (subclk_active) begin
            refuse_set = 1'b1;
          end else if (wake_any) begin
            state_d = smc_pkg::S_STAB;
            cnt_d = '0;
            vec_d = take_vec;
            stop_path_d = 1'b1;
            on_sub_d = 1'b0;
          end else begin
            state_d = smc_pkg::S_STOP;
            stop_path_d = 1'b1;
            on_sub_d = 1'b0;
          end
        end
      end
      smc_pkg::S_HALT: begin
        if (wake_any) begin
          state_d = smc_pkg::S_WAKE;
          vec_d = take_vec;
          lat_d = take_vec ? smc_pkg::WAKE_VEC_LOAD
                           : smc_pkg::WAKE_NEXT_LOAD;
        end
      end
      smc_pkg::S_STOP: begin
        if (wake_any) begin
          state_d = smc_pkg::S_STAB;
          cnt_d = '0;
          vec_d = take_vec;
        end
      end
      smc_pkg::S_STAB: begin
        // counting waits for the restarted oscillator
        if (osc_s2_q) begin
          if (cnt_q == stab_term) begin
            state_d = smc_pkg::S_WAKE;
            lat_d = vec_q ? smc_pkg::WAKE_VEC_LOAD
                          : smc_pkg::WAKE_NEXT_LOAD;
          end else begin
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      smc_pkg::S_WAKE: begin
        if (lat_q == 4'h0) begin
          state_d = smc_pkg::S_RUN;
          pulse_d = 1'b1;
          vtake_d = vec_q;
        end else begin
          lat_d = lat_q - 4'h1;
        end
      end
      default: begin
        state_d = smc_pkg::S_RUN;
      end
    endcase
  end

  // clock gating and peripheral run enables follow the next state
  always_comb begin
    clk_en_d = (state_d == smc_pkg::S_RUN);
    osc_en_d = (state_d != smc_pkg::S_STOP);
    per_d = '1;
    if (state_d != smc_pkg::S_RUN) begin
      per_d.adc = 1'b0;
      if (on_sub_d || stop_path_d) begin
        per_d.timer8a = cfg_q[smc_pkg::CFG_T8A_EXT];
        per_d.timer8b = cfg_q[smc_pkg::CFG_T8B_EXT];
        per_d.watch = cfg_q[smc_pkg::CFG_WATCH_SUB];
        per_d.timer16 = 1'b0;
        per_d.wdt = 1'b0;
        per_d.uart = 1'b0;
        per_d.sound = 1'b0;
        per_d.van = 1'b0;
        per_d.lcd = 1'b0;
        per_d.sio = cfg_q[smc_pkg::CFG_SIO_EXT];
      end
    end
  end

  // async reset returns to run: the cpu then fetches its reset vector
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= smc_pkg::S_RUN;
      lat_q <= 4'h0;
      cnt_q <= '0;
      vec_q <= 1'b0;
      on_sub_q <= 1'b0;
      stop_path_q <= 1'b0;
      pulse_q <= 1'b0;
      vtake_q <= 1'b0;
      clk_en_q <= 1'b1;
      osc_en_q <= 1'b1;
      per_q <= '1;
    end else begin
      state_q <= state_d;
      lat_q <= lat_d;
      cnt_q <= cnt_d;
      vec_q <= vec_d;
      on_sub_q <= on_sub_d;
      stop_path_q <= stop_path_d;
      pulse_q <= pulse_d;
      vtake_q <= vtake_d;
      clk_en_q <= clk_en_d;
      osc_en_q <= osc_en_d;
      per_q <= per_d;
    end
  end

  // apb slave: decode in setup, answer in the first access cycle
  always_comb begin
    setup = psel & ~penable;
    wr_en = psel & penable & ready_q & pwrite;
    stat_word = '0;
    stat_word[smc_pkg::STAT_HALT] = (state_q == smc_pkg::S_HALT);
    stat_word[smc_pkg::STAT_STOP] = (state_q == smc_pkg::S_STOP);
    stat_word[smc_pkg::STAT_STAB] = (state_q == smc_pkg::S_STAB);
    stat_word[smc_pkg::STAT_ON_SUB] = on_sub_q;
    stat_word[smc_pkg::STAT_LAST_VEC] = vec_q;
    stat_word[smc_pkg::STAT_STOP_REFUSED] = refused_q;
    ready_d = setup;
    rdata_d = rdata_q;
    err_d = 1'b0;
    if (setup) begin
      case (paddr)
        smc_pkg::REG_STAB_OFS: rdata_d = {24'h000000, stab_sel_q};
        smc_pkg::REG_CFG_OFS: rdata_d = {28'h0000000, cfg_q};
        smc_pkg::REG_STAT_OFS: rdata_d = stat_word;
        default: begin
          rdata_d = 32'h00000000;
          err_d = 1'b1;
        end
      endcase
    end
    stab_sel_d = stab_sel_q;
    cfg_d = cfg_q;
    if (wr_en && paddr == smc_pkg::REG_STAB_OFS) begin
      stab_sel_d = pwdata[7:0];
    end
    if (wr_en && paddr == smc_pkg::REG_CFG_OFS) begin
      cfg_d = pwdata[3:0];
    end
    // a refusal in the clearing cycle survives the write-one-to-clear
    refused_d = refused_q;
    if (wr_en && paddr == smc_pkg::REG_STAT_OFS
        && pwdata[smc_pkg::STAT_STOP_REFUSED]) begin
      refused_d = 1'b0;
    end
    if (refuse_set) begin
      refused_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stab_sel_q <= smc_pkg::STAB_SEL_RST;
      cfg_q <= smc_pkg::CFG_RST;
      refused_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      stab_sel_q <= stab_sel_d;
      cfg_q <= cfg_d;
      refused_q <= refused_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign cpu_clk_en = clk_en_q;
  assign main_osc_en = osc_en_q;
  assign wake_pulse = pulse_q;
  assign vector_take = vtake_q;
  assign per_run = per_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  halt_clock_off_a: assert property (
    state_q == smc_pkg::S_RUN && halt_instr |=> !cpu_clk_en && main_osc_en)
    else $error("halt entry did not gate cpu clock");

  stop_osc_off_a: assert property (
    state_q == smc_pkg::S_RUN && stop_instr && !halt_instr
    && !subclk_active && !wake_any |=> !main_osc_en && !cpu_clk_en)
    else $error("stop entry left main oscillator on");

  stop_on_sub_a: assert property (
    state_q == smc_pkg::S_RUN && stop_instr && !halt_instr
    && subclk_active |=> main_osc_en && cpu_clk_en && refused_q)
    else $error("stop accepted on subsystem clock");

  wake_vector_a: assert property (
    state_q == smc_pkg::S_HALT && wake_any && take_vec
    |-> !wake_pulse [*8] ##1 (wake_pulse && vector_take))
    else $error("vectored halt wake not after 8 clocks");

  wake_next_a: assert property (
    state_q == smc_pkg::S_HALT && wake_any && !take_vec
    |-> ##2 (wake_pulse && !vector_take && cpu_clk_en))
    else $error("non-vectored halt wake not after 2 clocks");

  nmi_vector_a: assert property (
    state_q == smc_pkg::S_HALT && irq.nmi_req |-> ##8 vector_take)
    else $error("nmi wake without vectored service");

  mask_hold_a: assert property (
    state_q == smc_pkg::S_HALT && !irq.nmi_req && irq.irq_mask_flag
    |=> state_q == smc_pkg::S_HALT)
    else $error("masked request left halt");

  stab_hold_a: assert property (
    state_q == smc_pkg::S_STAB && !osc_s2_q |=> $stable(cnt_q))
    else $error("stabilization counted before oscillation");

  stab_write_a: assert property (
    wr_en && paddr == smc_pkg::REG_STAB_OFS
    |=> stab_sel_q == $past(pwdata[7:0]))
    else $error("stabilization select write lost");

  adc_halt_a: assert property (
    !cpu_clk_en |-> !per_run.adc && per_run.ext_irq)
    else $error("adc running or ext irq off in standby");

  sub_halt_a: assert property (
    state_q == smc_pkg::S_HALT && on_sub_q
    |-> !per_run.timer16 && !per_run.wdt && !per_run.lcd
    && per_run.timer8a == cfg_q[smc_pkg::CFG_T8A_EXT])
    else $error("sub halt peripheral enables wrong");

endmodule : smc_ctrl

// ### tb/smc_osc_model.sv
// Purpose: main oscillator stand-in that drives osc_ready
// Assumes: a restart takes START_CYC sys_clk cycles after enable
// Notes: ready drops at once on disable, so a stale high is never seen
`timescale 1ns/1ns
module smc_osc_model #(
  parameter int START_CYC = 5
) (
  input wire logic sys_clk,
  input wire logic main_osc_en,
  output logic osc_ready
);
  int cnt_q;
  initial cnt_q = 0;
  always @(posedge sys_clk) begin
    if (main_osc_en !== 1'b1) begin
      cnt_q <= 0;
    end else if (cnt_q < START_CYC) begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign osc_ready = (main_osc_en === 1'b1) && (cnt_q >= START_CYC);
endmodule : smc_osc_model

// ### tb/smc_ctrl_tb.sv
// Purpose: self-checking bench for the standby mode controller
// Assumes: stabilization base exponent 1 keeps stop waits short
// Notes: the bench plays cpu, interrupt controller and apb master
`timescale 1ns/1ns
module smc_ctrl_tb;
  localparam int OSC_CYC = 5;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, err, vec;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic halt_instr, stop_instr, subclk_active, irq_accept_enable;
  logic in_service_priority, osc_ready, cpu_clk_en, main_osc_en;
  logic wake_pulse, vector_take;
  logic [4:0] cs [6];
  smc_pkg::smc_irq_t irq;
  smc_pkg::smc_per_run_t per_run;
  int n_mismatch, checks, cyc, n, n0;

  smc_ctrl #(.STAB_EXP_BASE(1)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_instr(halt_instr), .stop_instr(stop_instr),
    .subclk_active(subclk_active), .irq(irq),
    .irq_accept_enable(irq_accept_enable),
    .in_service_priority(in_service_priority), .osc_ready(osc_ready),
    .cpu_clk_en(cpu_clk_en), .main_osc_en(main_osc_en),
    .wake_pulse(wake_pulse), .vector_take(vector_take), .per_run(per_run));
  smc_osc_model #(.START_CYC(OSC_CYC)) osc_u (.sys_clk(sys_clk),
    .main_osc_en(main_osc_en), .osc_ready(osc_ready));

  task automatic end_sim;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // entered just after a rising edge; returns just after one
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps the next setup from re-driving psel at once
    @(posedge sys_clk);
  endtask : apb

  task automatic instr(input logic st);
    if (st) stop_instr <= 1'b1;
    else halt_instr <= 1'b1;
    @(posedge sys_clk);
    stop_instr <= 1'b0;
    halt_instr <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : instr

  // counts edges from raising the request to the wake pulse
  task automatic wake(input logic nm, output int cnt, output logic v);
    @(posedge sys_clk);
    irq.nmi_req <= nm;
    irq.irq_req <= !nm;
    irq.irq_mask_flag <= 1'b0;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end while (wake_pulse !== 1'b1 && cnt < 300);
    v = vector_take;
    @(posedge sys_clk);
    irq.nmi_req <= 1'b0;
    irq.irq_req <= 1'b0;
  endtask : wake

  function automatic logic [11:0] exp_run(input logic sub,
                                          input logic [3:0] c);
    if (!sub) return 12'hffb;
    return {1'b0, c[0], c[1], c[2], 6'h00, c[3], 1'b1};
  endfunction : exp_run

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    {resetn, psel, penable, pwrite, halt_instr, stop_instr} = 6'h00;
    {subclk_active, irq_accept_enable, in_service_priority} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq = '0;
    cs = '{5'h00, 5'h05, 5'h0a, 5'h0c, 5'h0f, 5'h11};
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h04);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h00, 32'h1a5);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'ha5);
    apb(1'b1, 8'h00, 32'h0);
    // halt on main clock, every wake decision
    foreach (cs[i]) begin
      irq.irq_priority_flag <= cs[i][3];
      irq_accept_enable <= cs[i][2];
      in_service_priority <= cs[i][1];
      instr(1'b0);
      chk({18'h0, cpu_clk_en, main_osc_en, per_run},
          {20'h1, exp_run(1'b0, 4'h0)});
      if (i == 0) begin
        @(posedge sys_clk);
        irq.irq_req <= 1'b1;
        irq.irq_mask_flag <= 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        chk({31'h0, cpu_clk_en}, 32'h0);
      end
      wake(cs[i][4], n, vec);
      chk(32'(n), cs[i][0] ? 32'h8 : 32'h2);
      chk({30'h0, vec, cpu_clk_en}, {30'h0, cs[i][0], 1'b1});
    end
    // halt on subclock with peripheral clock choices
    subclk_active <= 1'b1;
    irq_accept_enable <= 1'b0;
    for (int c = 5; c <= 10; c += 5) begin
      apb(1'b1, 8'h04, 32'(c));
      instr(1'b0);
      chk({20'h0, per_run}, {20'h0, exp_run(1'b1, 4'(c))});
      @(posedge sys_clk);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd & 32'h0000000f, 32'h9);
      wake(1'b0, n, vec);
    end
    @(posedge sys_clk);
    instr(1'b1);
    chk({30'h0, cpu_clk_en, main_osc_en}, 32'h3);
    @(posedge sys_clk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h100, 32'h100);
    apb(1'b1, 8'h08, 32'h100);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h100, 32'h0);
    // stop on main clock, two stabilization lengths
    subclk_active <= 1'b0;
    for (int s = 0; s <= 3; s += 3) begin
      apb(1'b1, 8'h00, 32'(s));
      instr(1'b1);
      chk({30'h0, cpu_clk_en, main_osc_en}, 32'h0);
      @(posedge sys_clk);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd & 32'h00000007, 32'h2);
      wake(1'b0, n, vec);
      chk({31'h0, n >= 2 ** (1 + s) + OSC_CYC + 2}, 32'h1);
      if (s == 0) n0 = n;
    end
    chk(32'(n - n0), 32'h0e);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h03);
    irq.irq_req <= 1'b1;
    irq.irq_mask_flag <= 1'b0;
    @(posedge sys_clk);
    instr(1'b1);
    chk({30'h0, cpu_clk_en, main_osc_en}, 32'h1);
    wake(1'b0, n, vec);
    chk({31'h0, n <= 2 ** 4 + 4}, 32'h1);
    @(posedge sys_clk);
    instr(1'b0);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk({30'h0, cpu_clk_en, wake_pulse}, 32'h2);
    @(posedge sys_clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h04);
    end_sim();
  end
endmodule : smc_ctrl_tb
